// file: src/feu_pkg.sv
package feu_pkg;

    // -------------------------------------------------------------------
    // vectors
    // -------------------------------------------------------------------
    localparam logic [7:0] VEC_DIVIDE      = 8'h00;
    localparam logic [7:0] VEC_NMI         = 8'h02;
    localparam logic [7:0] VEC_DOUBLE      = 8'h08;
    localparam logic [7:0] VEC_OVERRUN     = 8'h09;
    localparam logic [7:0] VEC_BAD_TASK    = 8'h0A;
    localparam logic [7:0] VEC_GEN_PROT    = 8'h0D;
    localparam logic [7:0] VEC_PAGE        = 8'h0E;

    // -------------------------------------------------------------------
    // task state block limits
    // -------------------------------------------------------------------
    localparam logic [31:0] TSB_MIN_LIMIT_32 = 32'h0000_0067;
    localparam logic [31:0] TSB_MIN_LIMIT_16 = 32'h0000_002C;

    // -------------------------------------------------------------------
    // register map (word aligned byte addresses)
    // -------------------------------------------------------------------
    localparam logic [11:0] ADDR_EXC_REQ    = 12'h000;
    localparam logic [11:0] ADDR_WAKE       = 12'h004;
    localparam logic [11:0] ADDR_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_DELIVER    = 12'h00C;
    localparam logic [11:0] ADDR_ERR_CODE   = 12'h010;
    localparam logic [11:0] ADDR_TS_SEL     = 12'h014;
    localparam logic [11:0] ADDR_TS_LIMIT   = 12'h018;
    localparam logic [11:0] ADDR_TS_DESC    = 12'h01C;
    localparam logic [11:0] ADDR_TS_CMD     = 12'h020;
    localparam logic [11:0] ADDR_TS_RESULT  = 12'h024;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        CLS_BENIGN,
        CLS_CONTRIB,
        CLS_PAGE
    } feu_class_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_INVOKE,
        ST_INVOKE_DF,
        ST_SHUTDOWN
    } feu_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } feu_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } feu_apb_rsp_t;

    typedef struct packed {
        feu_state_t  state;
        logic [7:0]  cur_vec;
        feu_class_t  cur_cls;
        logic        in_nmi;
        logic        nmi_at_shut;
        logic [7:0]  dlv_vec;
        logic        dlv_valid;
        logic        dlv_serial;
        logic [31:0] err_code;
        logic        shut_cycle;
        logic        halted;
        logic [15:0] ts_ss;
        logic [15:0] ts_cs;
        logic [15:0] ts_ds;
        logic [15:0] ts_ldt;
        logic [15:0] ts_tsb;
        logic [31:0] ts_limit;
        logic [15:0] ts_desc;
        logic [15:0] ts_res;
        logic        ts_done;
        logic        ts_fault;
        logic        ts_new_ctx;
        logic        ts_loaded;
        feu_apb_rsp_t apb;
    } feu_state_all_t;

endpackage

// file: src/feu_fault_escalation.sv
`timescale 1ns/1ps
module feu_fault_escalation (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire feu_pkg::feu_apb_req_t apb_req,
    output feu_pkg::feu_apb_rsp_t      apb_rsp,
    output logic [7:0]                 deliver_vec,
    output logic                       deliver_valid,
    output logic                       shutdown_cycle,
    output logic                       halted,
    output logic [31:0]                deliver_err_code
);
    import feu_pkg::*;

    feu_state_all_t s_ff;
    feu_state_all_t nxt_s;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // class lookup
    function automatic feu_class_t classify(input logic [7:0] v);
        if (v == VEC_DIVIDE || (v >= VEC_BAD_TASK && v <= VEC_GEN_PROT)) begin
            return CLS_CONTRIB;
        end else if (v == VEC_PAGE) begin
            return CLS_PAGE;
        end
        return CLS_BENIGN;
    endfunction

    function automatic logic escalates(input feu_class_t f, input feu_class_t n);
        return (f == CLS_CONTRIB && n == CLS_CONTRIB) ||
               (f == CLS_PAGE && n != CLS_BENIGN);
    endfunction

    function automatic logic [15:0] sel_code(input logic [15:0] sel, input logic external_event_flag);
        return {sel[15:3], 2'b00, external_event_flag};
    endfunction

    logic       wr;
    logic       rd;
    logic [7:0] req_vec;
    logic       ext_flag;

    always_comb begin
        wr       = apb_req.psel && apb_req.penable && apb_req.pwrite;
        // read decoded in setup so data stands with pready
        rd       = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        req_vec  = (apb_req.pwdata[7:0] == VEC_OVERRUN) ? VEC_GEN_PROT : apb_req.pwdata[7:0];
        ext_flag = apb_req.pwdata[31];
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [15:0] tsb_sel;
        logic        sz32;
        logic        ldt_bad;
        logic        ss_ok;
        logic        cs_ok;
        logic        ds_ok;
        logic [1:0]  current_privilege;
        logic        external_event_flag;
        logic        prefetch;
        feu_class_t  ncls;
        tsb_sel  = 16'h0000;
        sz32     = 1'b0;
        ldt_bad  = 1'b0;
        ss_ok    = 1'b0;
        cs_ok    = 1'b0;
        ds_ok    = 1'b0;
        current_privilege      = 2'b00;
        external_event_flag      = 1'b0;
        prefetch = 1'b0;
        ncls     = CLS_BENIGN;
        nxt_s    = s_ff;
        nxt_s.dlv_valid     = 1'b0;
        nxt_s.shut_cycle    = 1'b0;
        nxt_s.apb.pready    = 1'b0;
        nxt_s.apb.pslverr   = 1'b0;
        nxt_s.apb.prdata    = RST_WORD;

        if (apb_req.psel && !apb_req.penable) begin
            nxt_s.apb.pready = 1'b1;
        end

        // exception request: [7:0] vector, [8] prefetch, [9] handler done
        if (wr && s_ff.apb.pready && apb_req.paddr == ADDR_EXC_REQ) begin
            prefetch = apb_req.pwdata[8];
            ncls     = classify(req_vec);
            case (s_ff.state)
                ST_RUN: begin
                    if (!apb_req.pwdata[9]) begin
                        nxt_s.state   = ST_INVOKE;
                        nxt_s.cur_vec = req_vec;
                        nxt_s.cur_cls = ncls;
                        if (req_vec == VEC_NMI) begin
                            nxt_s.in_nmi = 1'b1;
                        end
                    end else begin
                        nxt_s.in_nmi = 1'b0;
                    end
                end
                ST_INVOKE: begin
                    if (apb_req.pwdata[9]) begin
                        // handler entered cleanly: deliver current vector
                        nxt_s.state     = ST_RUN;
                        nxt_s.dlv_vec   = s_ff.cur_vec;
                        nxt_s.dlv_valid = 1'b1;
                        nxt_s.dlv_serial = 1'b0;
                    end else if (!prefetch && escalates(s_ff.cur_cls, ncls)) begin
                        nxt_s.state     = ST_INVOKE_DF;
                        nxt_s.cur_vec   = VEC_DOUBLE;
                        nxt_s.cur_cls   = CLS_CONTRIB;
                        nxt_s.err_code  = 32'h0000_0000;
                    end else begin
                        nxt_s.dlv_vec    = s_ff.cur_vec;
                        nxt_s.dlv_valid  = 1'b1;
                        nxt_s.dlv_serial = 1'b1;
                        nxt_s.cur_vec    = req_vec;
                        nxt_s.cur_cls    = ncls;
                    end
                end
                ST_INVOKE_DF: begin
                    if (apb_req.pwdata[9]) begin
                        nxt_s.state     = ST_RUN;
                        nxt_s.dlv_vec   = VEC_DOUBLE;
                        nxt_s.dlv_valid = 1'b1;
                    end else begin
                        nxt_s.state       = ST_SHUTDOWN;
                        nxt_s.nmi_at_shut = s_ff.in_nmi;
                        nxt_s.shut_cycle  = 1'b1;
                    end
                end
                default: begin
                    nxt_s.state = ST_SHUTDOWN;
                end
            endcase
        end

        // wake: [0] nmi, [1] system mgmt, [2] init
        if (wr && s_ff.apb.pready && apb_req.paddr == ADDR_WAKE) begin
            if (s_ff.state == ST_SHUTDOWN && !s_ff.nmi_at_shut && |apb_req.pwdata[2:0]) begin
                nxt_s.state  = ST_RUN;
                nxt_s.in_nmi = apb_req.pwdata[0];
            end
        end

        if (wr && s_ff.apb.pready) begin
            if (apb_req.paddr == ADDR_TS_SEL) begin
                // [15:0] stack selector, [31:16] code selector
                nxt_s.ts_ss = apb_req.pwdata[15:0];
                nxt_s.ts_cs = apb_req.pwdata[31:16];
            end else if (apb_req.paddr == ADDR_TS_LIMIT) begin
                nxt_s.ts_limit = apb_req.pwdata;
            end else if (apb_req.paddr == ADDR_TS_DESC) begin
                // [15:0] data selector, [31:16] local table selector
                nxt_s.ts_ds  = apb_req.pwdata[15:0];
                nxt_s.ts_ldt = apb_req.pwdata[31:16];
            end
        end

        // task switch check: [15:0] task selector, [16] 32-bit format,
        // [17] local table bad, [18] ss ok, [19] cs ok, [20] ds ok,
        // [22:21] current privilege, [23] back-link set, [31] external
        if (wr && s_ff.apb.pready && apb_req.paddr == ADDR_TS_CMD) begin
            tsb_sel = apb_req.pwdata[15:0];
            sz32    = apb_req.pwdata[16];
            ldt_bad = apb_req.pwdata[17];
            ss_ok   = apb_req.pwdata[18];
            cs_ok   = apb_req.pwdata[19];
            ds_ok   = apb_req.pwdata[20];
            current_privilege     = apb_req.pwdata[22:21];
            external_event_flag     = ext_flag;
            nxt_s.ts_tsb     = tsb_sel;
            nxt_s.ts_fault   = 1'b1;
            nxt_s.ts_done    = 1'b0;
            nxt_s.ts_new_ctx = 1'b0;
            nxt_s.ts_loaded  = 1'b0;
            if (s_ff.ts_limit < (sz32 ? TSB_MIN_LIMIT_32 : TSB_MIN_LIMIT_16)) begin
                nxt_s.ts_res = sel_code(tsb_sel, external_event_flag);
            end else begin
                nxt_s.ts_new_ctx = 1'b1;
                nxt_s.ts_loaded  = 1'b1;
                nxt_s.ts_done    = apb_req.pwdata[23];
                if (ldt_bad) begin
                    nxt_s.ts_res = sel_code(s_ff.ts_ldt, external_event_flag);
                end else if (!ss_ok || s_ff.ts_ss[1:0] != current_privilege) begin
                    nxt_s.ts_res = sel_code(s_ff.ts_ss, external_event_flag);
                end else if (!cs_ok) begin
                    nxt_s.ts_res = sel_code(s_ff.ts_cs, external_event_flag);
                end else if (!ds_ok) begin
                    nxt_s.ts_res = sel_code(s_ff.ts_ds, external_event_flag);
                end else begin
                    nxt_s.ts_fault = 1'b0;
                    nxt_s.ts_res   = 16'h0000;
                end
            end
            if (nxt_s.ts_fault) begin
                nxt_s.dlv_vec   = VEC_BAD_TASK;
                nxt_s.dlv_valid = 1'b1;
                nxt_s.err_code  = {16'h0000, nxt_s.ts_res};
            end
        end

        if (rd && apb_req.paddr == ADDR_STATUS) begin
            nxt_s.apb.prdata = {24'h000000, 2'b00, s_ff.nmi_at_shut, s_ff.in_nmi,
                                2'b00, s_ff.state};
        end else if (rd && apb_req.paddr == ADDR_DELIVER) begin
            nxt_s.apb.prdata = {22'h000000, s_ff.dlv_serial, s_ff.dlv_valid, s_ff.dlv_vec};
        end else if (rd && apb_req.paddr == ADDR_ERR_CODE) begin
            nxt_s.apb.prdata = s_ff.err_code;
        end else if (rd && apb_req.paddr == ADDR_TS_RESULT) begin
            nxt_s.apb.prdata = {12'h000, s_ff.ts_loaded, s_ff.ts_new_ctx, s_ff.ts_done,
                                s_ff.ts_fault, s_ff.ts_res};
        end else if (rd && apb_req.paddr == ADDR_TS_LIMIT) begin
            nxt_s.apb.prdata = s_ff.ts_limit;
        end else if (apb_req.psel && !apb_req.penable &&
                     !(apb_req.paddr <= ADDR_TS_RESULT && apb_req.paddr[1:0] == 2'b00)) begin
            nxt_s.apb.pslverr = 1'b1;
        end
        nxt_s.halted = (nxt_s.state == ST_SHUTDOWN);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign apb_rsp          = s_ff.apb;
    assign deliver_vec      = s_ff.dlv_vec;
    assign deliver_valid    = s_ff.dlv_valid;
    assign shutdown_cycle   = s_ff.shut_cycle;
    assign halted           = s_ff.halted;
    assign deliver_err_code = s_ff.err_code;

endmodule // feu_fault_escalation

// file: test/feu_monitor.sv
`timescale 1ns/1ps
module feu_monitor (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire feu_pkg::feu_apb_req_t apb_req,
    input wire feu_pkg::feu_apb_rsp_t apb_rsp,
    input wire logic [7:0]            deliver_vec,
    input wire logic                  deliver_valid,
    input wire logic                  shutdown_cycle,
    input wire logic                  halted,
    input wire logic [31:0]           deliver_err_code
);
    import feu_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wake_wr;
    assign acc     = apb_req.psel && apb_req.penable;
    assign wake_wr = acc && apb_req.pwrite && apb_rsp.pready && (apb_req.paddr == ADDR_WAKE);
    // ------
    // bus handshake
    // ------
    ready_in_access_a: assert property (apb_rsp.pready |-> acc)
        else $error("pready outside access phase");
    ready_bound_a: assert property (acc && !apb_rsp.pready |-> ##[1:3] apb_rsp.pready)
        else $error("pready late");
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    // ------
    // escalation and shutdown
    // ------
    no_overrun_vec_a: assert property (deliver_valid |-> deliver_vec != VEC_OVERRUN)
        else $error("overrun vector delivered");
    df_zero_code_a: assert property (deliver_valid && deliver_vec == VEC_DOUBLE
        |-> deliver_err_code == 32'h0000_0000) else $error("double fault code not zero");
    shut_pulse_a: assert property (shutdown_cycle |-> halted ##1 !shutdown_cycle)
        else $error("shutdown cycle malformed");
    shut_entry_a: assert property ($rose(halted) |-> ##[0:1] shutdown_cycle)
        else $error("shutdown entered without bus cycle");
    shut_cause_a: assert property ($rose(halted) |->
        $past(apb_req.paddr) == ADDR_EXC_REQ && $past(apb_rsp.pready))
        else $error("shutdown without exception");
    halt_hold_a: assert property (halted && !wake_wr |=> halted)
        else $error("shutdown left without wake");
    shut_c: cover property (shutdown_cycle);
    df_c: cover property (deliver_valid && deliver_vec == VEC_DOUBLE);
    err_c: cover property (apb_rsp.pslverr);
endmodule // feu_monitor

bind feu_fault_escalation feu_monitor i_feu_monitor (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .deliver_vec(deliver_vec), .deliver_valid(deliver_valid),
    .shutdown_cycle(shutdown_cycle), .halted(halted), .deliver_err_code(deliver_err_code));

// file: test/feu_testbench.sv
`timescale 1ns/1ps
module testbench;
    import feu_pkg::*;
    logic         pclk;
    logic         presetn;
    feu_apb_req_t req;
    feu_apb_rsp_t rsp;
    logic [7:0]   dvec;
    logic         dvalid;
    logic         sdc;
    logic         halted;
    logic [31:0]  derr;
    logic [31:0]  rd;
    logic         er;
    int           bad_count = 0;
    int           cmp_count = 0;
    int           sd_seen   = 0;

    feu_fault_escalation i_feu_fault_escalation (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .deliver_vec(dvec),
        .deliver_valid(dvalid), .shutdown_cycle(sdc), .halted(halted), .deliver_err_code(derr));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) if (sdc === 1'b1) sd_seen <= sd_seen + 1;
    // ------
    // helpers
    // ------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // master waits on pready, never on a fixed latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, 32'(n < 20));
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    function automatic int cls(logic [7:0] v);
        if (v == 8'h00 || v == 8'h09 || (v >= 8'h0A && v <= 8'h0D)) return 1;
        return (v == 8'h0E) ? 2 : 0;
    endfunction
    // ------
    // scenarios
    // ------
    task automatic t_reset();
        rst();
        settle();
        chk("halted", 32'h0, 32'(halted));
        chk("deliver_vec", 32'h0, 32'(dvec));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped err", 32'h1, 32'(er));
        apb(1'b0, ADDR_ERR_CODE, 32'h0);
        chk("mapped err", 32'h0, 32'(er));
        $display("test reset done");
    endtask
    task automatic t_pairs();
        logic [16:0] tab [17];
        logic        df;
        int          c1;
        int          c2;
        tab = '{17'h00202, 17'h00200, 17'h0020E, 17'h00002, 17'h00000, 17'h0000E, 17'h00E02,
                17'h00E00, 17'h00E0E, 17'h0000A, 17'h0000B, 17'h0000C, 17'h0000D, 17'h00900,
                17'h10000, 17'h00E01, 17'h00E10};
        foreach (tab[i]) begin
            c1 = cls(tab[i][15:8]);
            c2 = cls(tab[i][7:0]);
            df = !tab[i][16] && ((c1 == 1 && c2 == 1) || (c1 == 2 && c2 != 0));
            rst();
            apb(1'b1, ADDR_EXC_REQ, {24'h0, tab[i][15:8]});
            settle();
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("invoke state", 32'h1, {30'h0, rd[1:0]});
            apb(1'b1, ADDR_EXC_REQ, {23'h0, tab[i][16], tab[i][7:0]});
            settle();
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("double", df ? 32'h2 : 32'h1, {30'h0, rd[1:0]});
            if (!df) begin
                chk("first vec", (tab[i][15:8] == 8'h09) ? 32'h0D : 32'(tab[i][15:8]), 32'(dvec));
            end
            apb(1'b1, ADDR_EXC_REQ, 32'h0000_0200);
            settle();
            chk("entered vec", df ? 32'h08 : 32'(tab[i][7:0]), 32'(dvec));
            if (df) begin
                chk("df code", 32'h0, derr);
            end
        end
        $display("test pairs done");
    endtask
    task automatic t_shut();
        logic [7:0] seq [3];
        logic [7:0] v;
        seq = '{8'h00, 8'h0D, 8'h0E};
        for (int w = 0; w < 3; w++) begin
            rst();
            sd_seen = 0;
            foreach (seq[k]) begin
                apb(1'b1, ADDR_EXC_REQ, {24'h0, seq[k]});
                settle();
            end
            chk("halted", 32'h1, 32'(halted));
            chk("shutdown pulses", 32'h1, 32'(sd_seen));
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("state", 32'h3, {30'h0, rd[1:0]});
            v = dvec;
            apb(1'b1, ADDR_EXC_REQ, 32'h0);
            apb(1'b1, ADDR_WAKE, 32'h0);
            settle();
            chk("still halted", 32'h1, 32'(halted));
            chk("vec kept", 32'(v), 32'(dvec));
            apb(1'b1, ADDR_WAKE, 32'h1 << w);
            settle();
            chk("woken", 32'h0, 32'(halted));
        end
        $display("test shutdown done");
    endtask
    task automatic t_nmi();
        logic [7:0] seq [3];
        seq = '{8'h00, 8'h0D, 8'h0E};
        rst();
        apb(1'b1, ADDR_EXC_REQ, 32'h0000_0002);
        apb(1'b1, ADDR_EXC_REQ, 32'h0000_0200);
        settle();
        foreach (seq[k]) begin
            apb(1'b1, ADDR_EXC_REQ, {24'h0, seq[k]});
            settle();
        end
        chk("nmi halted", 32'h1, 32'(halted));
        apb(1'b1, ADDR_WAKE, 32'h0000_0007);
        settle();
        chk("nmi still halted", 32'h1, 32'(halted));
        rst();
        settle();
        chk("reset wakes", 32'h0, 32'(halted));
        $display("test nmi shutdown done");
    endtask
    task automatic t_task();
        logic [31:0] lim [10];
        logic [31:0] cmd [10];
        logic [17:0] ex [10];
        int          n;
        lim = '{32'h66, 32'h67, 32'h2B, 32'h2C, 32'h67, 32'h67, 32'h67, 32'h67, 32'h66, 32'h67};
        cmd = '{32'h001D0028, 32'h009D0028, 32'h001C0028, 32'h001C0028, 32'h001F0028,
                32'h00190028, 32'h00150028, 32'h000D0028, 32'h801D0028, 32'h003D0028};
        ex = '{18'h10028, 18'h0, 18'h10028, 18'h0, 18'h30030, 18'h30010, 18'h30018,
               18'h30020, 18'h10029, 18'h30010};
        foreach (lim[i]) begin
            rst();
            apb(1'b1, ADDR_TS_SEL, 32'h0018_0010);
            apb(1'b1, ADDR_TS_DESC, 32'h0030_0020);
            apb(1'b1, ADDR_TS_LIMIT, lim[i]);
            apb(1'b0, ADDR_TS_LIMIT, 32'h0);
            chk("limit readback", lim[i], rd);
            apb(1'b1, ADDR_TS_CMD, cmd[i]);
            n = (lim[i] >= (cmd[i][16] ? 32'h67 : 32'h2C)) ? 1 : 0;
            apb(1'b0, ADDR_TS_RESULT, 32'h0);
            chk("ts done", 32'(n == 1 && cmd[i][23]), 32'(rd[17]));
            chk("ts fault", 32'(ex[i][16]), 32'(rd[16]));
            if (ex[i][16]) begin
                chk("ts code", {16'h0, ex[i][15:0]}, {16'h0, rd[15:0]});
                chk("ts new ctx", 32'(ex[i][17]), 32'(rd[18]));
                chk("ts loaded", 32'(ex[i][17]), 32'(rd[19]));
            end
        end
        $display("test task switch done");
    endtask
    // ------
    // run control
    // ------
    task automatic results();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        results();
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        t_reset();
        t_pairs();
        t_shut();
        t_nmi();
        t_task();
        results();
    end
endmodule // testbench
